// file: core/bl_pkg.sv
// Purpose: shared constants and types of the boot loader link and both ends
// Assumes: pclk at 250 MHz, 32 kHz oscillator shared by both ends
// Notes: async bit time is counted in oscillator ticks
package bl_pkg;
    typedef logic [7:0] bl_byte_t;
    typedef logic [1:0] bl_mode_t;
    localparam bl_mode_t BL_MODE_OFF = 2'h0;
    localparam bl_mode_t BL_MODE_SLAVE = 2'h1;
    localparam bl_mode_t BL_MODE_CLKSER = 2'h2;
    localparam bl_mode_t BL_MODE_ASYNC = 2'h3;
    localparam int BL_CLK_MHZ = 250;
    localparam int BL_OSC_HZ = 32768;
    localparam int BL_BAUD = 2400;
    localparam logic [3:0] BL_BIT_TICKS = 4'((BL_OSC_HZ + BL_BAUD / 2) / BL_BAUD);
    localparam logic [3:0] BL_HALF_TICKS = 4'(BL_BIT_TICKS / 2);
    localparam int BL_SCLK_PERIOD_NS = 32;
    localparam logic [3:0] BL_SCLK_HALF_CYC = 4'(BL_SCLK_PERIOD_NS * BL_CLK_MHZ / 2000);
    localparam int BL_STROBE_NS = 40;
    localparam logic [3:0] BL_STROBE_CYC = 4'((BL_STROBE_NS * BL_CLK_MHZ + 999) / 1000);
    localparam int BL_HOLD_NS = 48;
    localparam logic [3:0] BL_HOLD_CYC = 4'((BL_HOLD_NS * BL_CLK_MHZ + 999) / 1000);
    localparam logic [3:0] BL_CLKSER_LAST = 4'h7;
    localparam logic [3:0] BL_ASYNC_LAST = 4'h9;
    localparam int BL_ROM_AW = 4;
    localparam logic [15:0] BL_RESET_VEC = 16'h0000;
    localparam int BL_IO_SEL_BIT = 7;
    localparam bl_byte_t BL_IO_SLAVE_PORT_CONTROL_REG = 8'h24;
    localparam bl_byte_t BL_IO_PC_DATA = 8'h50;
    localparam bl_byte_t BL_IO_PC_FUNC = 8'h55;
    localparam int BL_SLAVE_PORT_CONTROL_REG_TERM_BIT = 7;
    localparam int BL_TX_BIT = 6;
    localparam bl_byte_t BL_REG_RST = 8'h00;
    // boot program image; the loader sequence itself is done in hardware
    localparam bl_byte_t BL_BOOT_ROM [16] = '{default: 8'h00};
    localparam logic [7:0] BL_APB_CTRL = 8'h00;
    localparam logic [7:0] BL_APB_DATA = 8'h04;
    localparam logic [7:0] BL_APB_STATUS = 8'h08;
    localparam int BL_ST_EMPTY_BIT = 2;
    localparam int BL_ST_BUSY_BIT = 3;
endpackage : bl_pkg

// file: core/bl_link_if.sv
// Purpose: pins between the boot host and the device
// Assumes: osc32k is driven by the bench and read by both ends
// Notes: all pins are one-way during boot
`timescale 1ns/1ps
interface bl_link_if;
    logic [1:0] boot_select_pins;
    logic [7:0] slave_data;
    logic [1:0] slave_addr;
    logic slave_cs_n;
    logic slave_wr_n;
    logic write_empty;
    logic serial_clk;
    logic serial_data;
    logic serial_a_tx_out;
    logic osc32k;
    modport dev (
        input boot_select_pins, slave_data, slave_addr, slave_cs_n, slave_wr_n,
        input serial_clk, serial_data, osc32k,
        output write_empty, serial_a_tx_out
    );
    modport host (
        output boot_select_pins, slave_data, slave_addr, slave_cs_n, slave_wr_n,
        output serial_clk, serial_data,
        input write_empty, serial_a_tx_out, osc32k
    );
endinterface : bl_link_if

// file: core/bl_sync.sv
// Purpose: two-flop synchroniser with rising edge detect
// Assumes: inputs come from outside the pclk domain
// Notes: INIT is the idle level of the pins
`timescale 1ns/1ps
module bl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] rise
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] prev_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= INIT;
            q <= INIT;
            prev_reg <= INIT;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
            prev_reg <= q;
        end
    end
    assign rise = q & ~prev_reg;
endmodule : bl_sync

// file: core/bl_device_end.sv
// Purpose: device end of the boot loader: triplet receiver and fetch takeover
// Assumes: cpu presents fetches on fetch_req/fetch_addr and obeys mem_fetch_en
// Notes: watchdog itself is outside; wd_clear pulses once per received byte
`timescale 1ns/1ps
module bl_device_end (
    input wire logic pclk,
    input wire logic presetn,
    bl_link_if.dev link,
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    output logic mem_fetch_en,
    output logic boot_active,
    output bl_pkg::bl_byte_t rom_data,
    output logic resume_valid,
    output logic [15:0] resume_addr,
    output logic mem_wr,
    output logic [15:0] mem_wr_addr,
    output bl_pkg::bl_byte_t mem_wr_data,
    output logic io_wr,
    output logic [15:0] io_wr_addr,
    output bl_pkg::bl_byte_t io_wr_data,
    output logic wd_clear,
    input wire logic cpu_io_wr,
    input wire bl_pkg::bl_byte_t cpu_io_addr,
    input wire bl_pkg::bl_byte_t cpu_io_wdata
);
    import bl_pkg::*;

    typedef enum {S_IDLE, S_AHI, S_ALO, S_DATA} bl_state_t;
    bl_state_t state_reg, state_next;

    logic [1:0] sel_s;
    logic cs_n_s;
    logic [1:0] addr_s;
    bl_byte_t data_s;
    logic sdata_s;
    logic [2:0] edge_rise;

    bl_sync #(.W(14), .INIT(14'h0801)) u_lvl (
        .pclk(pclk),
        .presetn(presetn),
        .d({link.boot_select_pins, link.slave_cs_n, link.slave_addr, link.slave_data, link.serial_data}),
        .q({sel_s, cs_n_s, addr_s, data_s, sdata_s}),
        .rise()
    );
    bl_sync #(.W(3), .INIT(3'h4)) u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .d({link.slave_wr_n, link.serial_clk, link.osc32k}),
        .q(),
        .rise(edge_rise)
    );

    wire wr_rise = edge_rise[2];
    wire sclk_rise = edge_rise[1];
    wire osc_tick = edge_rise[0];

    bl_mode_t mode_reg;
    bl_byte_t slave_port_control_reg_reg, pc_data_reg, pc_func_reg;
    bl_byte_t hold_reg, addr_hi_reg, addr_lo_reg, shift_reg;
    logic full_reg, done_reg, rx_on_reg;
    // chip select rises with the write strobe, so its level one cycle earlier qualifies the strobe
    logic cs_n_d_reg;
    logic [3:0] bit_reg, tick_reg;

    wire active = (state_reg != S_IDLE);
    wire term = slave_port_control_reg_reg[BL_SLAVE_PORT_CONTROL_REG_TERM_BIT];
    wire start_ev = fetch_req && (fetch_addr[BL_ROM_AW-1:0] == '0) && (sel_s != BL_MODE_OFF)
        && !term && !active;
    wire end_ev = active && ((sel_s == BL_MODE_OFF) || term);
    wire take = active && !end_ev && full_reg;
    wire to_io = addr_hi_reg[BL_IO_SEL_BIT];
    wire ld_io = take && (state_reg == S_DATA) && to_io;
    wire ld_mem = take && (state_reg == S_DATA) && !to_io;
    wire slave_acc = active && (mode_reg == BL_MODE_SLAVE) && wr_rise && !cs_n_d_reg
        && (addr_s == 2'h0);
    wire clk_bit = active && (mode_reg == BL_MODE_CLKSER) && sclk_rise;
    wire async_tk = active && (mode_reg == BL_MODE_ASYNC) && osc_tick;
    wire rx_set = slave_acc || done_reg;
    wire reg_wr = ld_io || cpu_io_wr;
    wire [7:0] reg_addr = ld_io ? addr_lo_reg : cpu_io_addr;
    wire [7:0] reg_data = ld_io ? hold_reg : cpu_io_wdata;

    assign mem_fetch_en = !(active || start_ev);
    assign boot_active = active;
    assign link.write_empty = !full_reg;

    always_comb begin
        state_next = state_reg;
        if (start_ev) begin
            state_next = S_AHI;
        end else if (end_ev) begin
            state_next = S_IDLE;
        end else if (take) begin
            case (state_reg)
                S_AHI: state_next = S_ALO;
                S_ALO: state_next = S_DATA;
                S_DATA: state_next = S_AHI;
                default: state_next = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            mode_reg <= BL_MODE_OFF;
            resume_addr <= BL_RESET_VEC;
            resume_valid <= 1'b0;
            rom_data <= BL_REG_RST;
            cs_n_d_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cs_n_d_reg <= cs_n_s;
            resume_valid <= end_ev;
            rom_data <= BL_BOOT_ROM[fetch_addr[BL_ROM_AW-1:0]];
            if (start_ev) begin
                mode_reg <= sel_s;
                resume_addr <= fetch_addr;
            end
        end
    end

    // receive holding byte; a new byte wins over consumption
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_reg <= 1'b0;
            hold_reg <= BL_REG_RST;
            addr_hi_reg <= BL_REG_RST;
            addr_lo_reg <= BL_REG_RST;
        end else begin
            if (rx_set) begin
                full_reg <= 1'b1;
                hold_reg <= slave_acc ? data_s : shift_reg;
            end else if (take || !active) begin
                full_reg <= 1'b0;
            end
            if (take && state_reg == S_AHI) begin
                addr_hi_reg <= hold_reg;
            end
            if (take && state_reg == S_ALO) begin
                addr_lo_reg <= hold_reg;
            end
        end
    end

    // serial receiver: clocked mode on sclk edges, async mode on oscillator ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg <= BL_REG_RST;
            bit_reg <= '0;
            tick_reg <= '0;
            rx_on_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (!active) begin
                bit_reg <= '0;
                rx_on_reg <= 1'b0;
            end else if (clk_bit) begin
                shift_reg <= {sdata_s, shift_reg[7:1]};
                bit_reg <= (bit_reg == BL_CLKSER_LAST) ? 4'h0 : bit_reg + 4'h1;
                done_reg <= (bit_reg == BL_CLKSER_LAST);
            end else if (async_tk && !rx_on_reg) begin
                if (!sdata_s) begin
                    rx_on_reg <= 1'b1;
                    tick_reg <= BL_HALF_TICKS - 4'h1;
                    bit_reg <= '0;
                end
            end else if (async_tk) begin
                if (tick_reg != 4'h0) begin
                    tick_reg <= tick_reg - 4'h1;
                end else begin
                    tick_reg <= BL_BIT_TICKS - 4'h1;
                    bit_reg <= bit_reg + 4'h1;
                    if (bit_reg == 4'h0 && sdata_s) begin
                        rx_on_reg <= 1'b0;
                    end else if (bit_reg == BL_ASYNC_LAST) begin
                        rx_on_reg <= 1'b0;
                        done_reg <= sdata_s;
                    end else if (bit_reg != 4'h0) begin
                        shift_reg <= {sdata_s, shift_reg[7:1]};
                    end
                end
            end
        end
    end

    // write outputs and internal peripheral registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_wr <= 1'b0;
            io_wr <= 1'b0;
            wd_clear <= 1'b0;
            mem_wr_addr <= '0;
            mem_wr_data <= BL_REG_RST;
            io_wr_addr <= '0;
            io_wr_data <= BL_REG_RST;
            slave_port_control_reg_reg <= BL_REG_RST;
            pc_data_reg <= BL_REG_RST;
            pc_func_reg <= BL_REG_RST;
            link.serial_a_tx_out <= 1'b0;
        end else begin
            mem_wr <= ld_mem;
            io_wr <= ld_io;
            wd_clear <= take;
            if (ld_mem) begin
                mem_wr_addr <= {addr_hi_reg, addr_lo_reg};
                mem_wr_data <= hold_reg;
            end
            if (ld_io) begin
                io_wr_addr <= {addr_hi_reg, addr_lo_reg};
                io_wr_data <= hold_reg;
            end
            if (reg_wr && reg_addr == BL_IO_SLAVE_PORT_CONTROL_REG) begin
                slave_port_control_reg_reg <= reg_data;
            end
            if (reg_wr && reg_addr == BL_IO_PC_DATA) begin
                pc_data_reg <= reg_data;
            end
            if (reg_wr && reg_addr == BL_IO_PC_FUNC) begin
                pc_func_reg <= reg_data;
            end
            link.serial_a_tx_out <= pc_func_reg[BL_TX_BIT] ? 1'b1 : pc_data_reg[BL_TX_BIT];
        end
    end
endmodule : bl_device_end

// file: core/bl_host_end.sv
// Purpose: boot host: APB-controlled sender of boot bytes over the link
// Assumes: software paces serial bytes itself, no interlock there
// Notes: APB answers with zero wait states
`timescale 1ns/1ps
module bl_host_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    bl_link_if.host link
);
    import bl_pkg::*;

    typedef enum {H_IDLE, H_WAIT_EMPTY, H_STROBE, H_HOLD, H_SHIFT} bl_hstate_t;
    bl_hstate_t state_reg;

    bl_mode_t ctrl_reg;
    logic [9:0] sh_reg;
    logic [3:0] cnt_reg, bit_reg, div_reg;
    logic sclk_reg;
    logic empty_s;
    logic [1:0] hs_rise;
    logic osc_lvl;

    bl_sync #(.W(2), .INIT(2'h2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({link.write_empty, link.osc32k}),
        .q({empty_s, osc_lvl}),
        .rise(hs_rise)
    );

    wire osc_tick = hs_rise[0];
    wire busy = (state_reg != H_IDLE);
    wire sel_ctrl = (paddr == BL_APB_CTRL);
    wire sel_data = (paddr == BL_APB_DATA);
    wire sel_stat = (paddr == BL_APB_STATUS);
    wire mapped = sel_ctrl || sel_data || sel_stat;
    wire acc = psel && penable;
    wire wr_ctrl = acc && pwrite && sel_ctrl;
    wire send = acc && pwrite && sel_data && !busy;
    wire is_async = (ctrl_reg == BL_MODE_ASYNC);
    wire div_tick = (div_reg == BL_SCLK_HALF_CYC - 4'h1);
    wire step = is_async ? (osc_tick && cnt_reg == BL_BIT_TICKS - 4'h1) : (div_tick && sclk_reg);
    wire [3:0] last_bit = is_async ? BL_ASYNC_LAST : BL_CLKSER_LAST;
    wire [31:0] rd_mux = sel_ctrl ? {30'h0, ctrl_reg} :
        sel_stat ? {28'h0, busy, empty_s, ctrl_reg} : 32'h0;

    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign link.boot_select_pins = ctrl_reg;
    assign link.slave_addr = 2'h0;
    assign link.serial_data = sh_reg[0];
    assign link.serial_clk = sclk_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= BL_MODE_OFF;
            prdata <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= bl_mode_t'(pwdata[1:0]);
            end
            if (psel && !penable) begin
                prdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= H_IDLE;
            sh_reg <= '1;
            cnt_reg <= '0;
            bit_reg <= '0;
            div_reg <= '0;
            sclk_reg <= 1'b0;
            link.slave_data <= BL_REG_RST;
            link.slave_cs_n <= 1'b1;
            link.slave_wr_n <= 1'b1;
        end else begin
            case (state_reg)
                H_IDLE: begin
                    if (send && ctrl_reg == BL_MODE_SLAVE) begin
                        link.slave_data <= pwdata[7:0];
                        state_reg <= H_WAIT_EMPTY;
                    end else if (send && ctrl_reg != BL_MODE_OFF) begin
                        sh_reg <= is_async ? {1'b1, pwdata[7:0], 1'b0} : {2'h3, pwdata[7:0]};
                        cnt_reg <= '0;
                        bit_reg <= '0;
                        div_reg <= '0;
                        state_reg <= H_SHIFT;
                    end
                end
                H_WAIT_EMPTY: begin
                    if (empty_s) begin
                        link.slave_cs_n <= 1'b0;
                        link.slave_wr_n <= 1'b0;
                        cnt_reg <= BL_STROBE_CYC - 4'h1;
                        state_reg <= H_STROBE;
                    end
                end
                H_STROBE: begin
                    cnt_reg <= cnt_reg - 4'h1;
                    if (cnt_reg == 4'h0) begin
                        link.slave_cs_n <= 1'b1;
                        link.slave_wr_n <= 1'b1;
                        cnt_reg <= BL_HOLD_CYC - 4'h1;
                        state_reg <= H_HOLD;
                    end
                end
                H_HOLD: begin
                    cnt_reg <= cnt_reg - 4'h1;
                    if (cnt_reg == 4'h0) begin
                        state_reg <= H_IDLE;
                    end
                end
                H_SHIFT: begin
                    div_reg <= div_tick ? 4'h0 : div_reg + 4'h1;
                    if (div_tick && !is_async) begin
                        sclk_reg <= !sclk_reg;
                    end
                    if (is_async && osc_tick) begin
                        cnt_reg <= (cnt_reg == BL_BIT_TICKS - 4'h1) ? 4'h0 : cnt_reg + 4'h1;
                    end
                    if (step) begin
                        sh_reg <= {1'b1, sh_reg[9:1]};
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == last_bit) begin
                            state_reg <= H_IDLE;
                        end
                    end
                end
                default: state_reg <= H_IDLE;
            endcase
        end
    end
endmodule : bl_host_end

// file: testbench/bl_link_assertions.sv
// Purpose: wire-level checks on the link between boot host and device
// Assumes: both ends are design code, pclk domain only
// Notes: instantiated beside the link interface in the bench top
`timescale 1ns/1ps
module bl_link_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] boot_select_pins,
    input wire logic [7:0] slave_data,
    input wire logic [1:0] slave_addr,
    input wire logic slave_cs_n,
    input wire logic slave_wr_n,
    input wire logic write_empty,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic serial_a_tx_out
);
    import bl_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    addr_zero_a: assert property (!slave_cs_n |-> slave_addr == 2'h0)
        else $error("slave address not zero while selected");
    wait_empty_a: assert property ($fell(slave_wr_n) |-> write_empty)
        else $error("slave write began while not empty");
    strobe_width_a: assert property ($fell(slave_wr_n) |-> (!slave_wr_n && !slave_cs_n) [*8])
        else $error("slave write strobe too short");
    data_hold_a: assert property ($rose(slave_wr_n) |-> $stable(slave_data) [*8])
        else $error("slave data not held after strobe");
    empty_falls_a: assert property ($rose(slave_wr_n) && boot_select_pins == BL_MODE_SLAVE |-> ##[1:8] !write_empty)
        else $error("write empty did not drop after a byte");
    sclk_idle_a: assert property (boot_select_pins != BL_MODE_CLKSER |-> !serial_clk)
        else $error("serial clock moves outside clocked mode");
    sclk_high_a: assert property ($rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk)
        else $error("serial clock high phase wrong");
    sdata_setup_a: assert property ($rose(serial_clk) |-> $stable(serial_data))
        else $error("serial data changed on clock rise");
    start_bit_a: assert property ($fell(serial_data) && boot_select_pins == BL_MODE_ASYNC |-> !serial_data [*8])
        else $error("async start bit too short");
    line_idle_a: assert property (boot_select_pins == BL_MODE_OFF |-> serial_data && slave_wr_n)
        else $error("link not idle with boot off");
    tx_reset_low_a: assert property ($rose(presetn) |-> !serial_a_tx_out)
        else $error("transmit line not low after reset");
endmodule : bl_link_assertions

// file: testbench/bootstrap_loader_tb.sv
// Purpose: bench for the boot loader, host and device ends joined by the link
// Assumes: 250 MHz pclk, oscillator runs at 32 ns so async frames stay short
// Notes: expected writes wait in a queue and are matched at every write pulse
`timescale 1ns/1ps
module bootstrap_loader_tb;
    import bl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, en;
    logic fetch_req, mem_fetch_en, boot_active, resume_valid, mem_wr, io_wr, wd_clear, cpu_io_wr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] fetch_addr, resume_addr, mem_wr_addr, io_wr_addr, start, res_addr;
    bl_byte_t rom_data, mem_wr_data, io_wr_data, cpu_io_addr, cpu_io_wdata;
    logic [23:0] exp_q[$];
    logic [23:0] e;
    int n_fail = 0, checks = 0, wd_cnt = 0, wd_exp = 0, res_cnt = 0, seed = 32'h4805, n, m, k;
    bl_link_if link();
    bl_device_end bl_device_end_inst (.pclk(pclk), .presetn(presetn), .link(link), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .mem_fetch_en(mem_fetch_en), .boot_active(boot_active), .rom_data(rom_data),
        .resume_valid(resume_valid), .resume_addr(resume_addr), .mem_wr(mem_wr), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data), .io_wr(io_wr), .io_wr_addr(io_wr_addr), .io_wr_data(io_wr_data),
        .wd_clear(wd_clear), .cpu_io_wr(cpu_io_wr), .cpu_io_addr(cpu_io_addr), .cpu_io_wdata(cpu_io_wdata));
    bl_host_end bl_host_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    bl_link_assertions bl_link_assertions_inst (.pclk(pclk), .presetn(presetn),
        .boot_select_pins(link.boot_select_pins), .slave_data(link.slave_data), .slave_addr(link.slave_addr),
        .slave_cs_n(link.slave_cs_n), .slave_wr_n(link.slave_wr_n), .write_empty(link.write_empty),
        .serial_clk(link.serial_clk), .serial_data(link.serial_data), .serial_a_tx_out(link.serial_a_tx_out));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        link.osc32k = 1'b0;
        forever #16 link.osc32k = ~link.osc32k;
    end
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task tally_and_finish;
        if (n_fail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // one byte over the link; the host is polled until it goes idle
    task send(input bl_byte_t b);
        apb(1'b1, BL_APB_DATA, {24'h0, b});
        wd_exp++;
        do apb(1'b0, BL_APB_STATUS, 32'h0); while (r[BL_ST_BUSY_BIT] !== 1'b0);
        repeat (40) @(posedge pclk);
    endtask : send
    task trip(input logic [15:0] a, input bl_byte_t d);
        exp_q.push_back({a, d});
        send(a[15:8]);
        send(a[7:0]);
        send(d);
    endtask : trip
    task fetch(input logic [15:0] a);
        @(posedge pclk);
        fetch_req <= 1'b1;
        fetch_addr <= a;
        @(negedge pclk);
        en = mem_fetch_en;
        @(posedge pclk);
        fetch_req <= 1'b0;
        repeat (3) @(negedge pclk);
    endtask : fetch
    // one cpu write to an internal register, then time for the transmit pin to follow
    task cpu_wr(input bl_byte_t a, input bl_byte_t d);
        @(posedge pclk);
        cpu_io_wr <= 1'b1;
        cpu_io_addr <= a;
        cpu_io_wdata <= d;
        @(posedge pclk);
        cpu_io_wr <= 1'b0;
        repeat (2) @(negedge pclk);
    endtask : cpu_wr
    always @(negedge pclk) begin
        if (presetn === 1'b1 && wd_clear === 1'b1) begin
            wd_cnt++;
        end
        if (presetn === 1'b1 && (mem_wr === 1'b1 || io_wr === 1'b1)) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 24'hX;
            check("write_is_io", {15'h0, io_wr}, {15'h0, e[23]});
            check("write_addr", io_wr ? io_wr_addr : mem_wr_addr, e[23:8]);
            check("write_data", {8'h0, io_wr ? io_wr_data : mem_wr_data}, {8'h0, e[7:0]});
        end
        if (resume_valid === 1'b1) begin
            res_cnt++;
            res_addr = resume_addr;
        end
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {fetch_req, fetch_addr, cpu_io_wr, cpu_io_addr, cpu_io_wdata} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(negedge pclk);
        check("tx_after_reset", {15'h0, link.serial_a_tx_out}, 16'h0);
        apb(1'b0, 8'h0C, 32'h0);
        check("unmapped_err", {15'h0, err}, 16'h1);
        apb(1'b0, BL_APB_STATUS, 32'h0);
        check("status_reset", r[15:0], 16'h0004);
        fetch(BL_RESET_VEC);
        check("boot_off", {14'h0, en, boot_active}, 16'h2);
        for (m = 1; m < 4; m++) begin
            apb(1'b1, BL_APB_CTRL, 32'(m));
            repeat (8) @(posedge pclk);
            fetch(16'hA5C1);
            check("misaligned_start", {15'h0, boot_active}, 16'h0);
            start = 16'($random(seed)) & 16'hFFF0;
            fetch(start);
            check("boot_start", {14'h0, en, boot_active}, 16'h1);
            check("rom_out", {8'h0, rom_data}, {8'h0, BL_BOOT_ROM[0]});
            check("fetch_held", {15'h0, mem_fetch_en}, 16'h0);
            repeat (2) trip(16'($random(seed)) & 16'h7FFF, 8'($random(seed)));
            trip(m == 2 ? {8'h80, BL_IO_PC_FUNC} : {8'h80, BL_IO_PC_DATA}, 8'h40);
            check("tx_raised", {15'h0, link.serial_a_tx_out}, 16'h1);
            check("wd_clears", 16'(wd_cnt), 16'(wd_exp));
            n = res_cnt;
            if (m == 1) begin
                trip({8'h80, BL_IO_SLAVE_PORT_CONTROL_REG}, 8'h80);
            end else begin
                apb(1'b1, BL_APB_CTRL, 32'h0);
            end
            k = 0;
            while (res_cnt == n && k < 2000) begin
                @(negedge pclk);
                k++;
            end
            check("resume_seen", 16'(res_cnt - n), 16'h1);
            check("resume_addr", res_addr, start);
            check("boot_ended", {14'h0, mem_fetch_en, boot_active}, 16'h2);
            if (m == 1) begin
                fetch(16'h0000);
                check("term_blocks", {15'h0, boot_active}, 16'h0);
                apb(1'b1, BL_APB_CTRL, 32'h0);
                cpu_wr(BL_IO_SLAVE_PORT_CONTROL_REG, 8'h00);
                cpu_wr(BL_IO_PC_DATA, 8'h00);
                check("tx_cleared", {15'h0, link.serial_a_tx_out}, 16'h0);
            end
        end
        check("writes_left", 16'(exp_q.size()), 16'h0);
        tally_and_finish();
    end
endmodule : bootstrap_loader_tb
